// ---- dac_volume_pkg.sv ----
// Function
// - low attenuation register holds five LSBs per channel, 0.125 dB per code.
// - high attenuation register holds five MSBs per channel, 4 dB per code.
// - write with apply bit clear stores value, attenuation in effect unchanged.
// - write with apply bit set stores value and applies all four registers.
// - gradual bit set ramps old to new attenuation after apply, else steps.
// - headroom cut bit set lowers sample path gain by 2 dB, else unity.
// - link bit set makes right channel use left attenuation.
// - soft mute bit set soft mutes both channels, clear resumes.
// - zero detect enable finds a run of 1024 zero input samples.
// - indicator source 00 AND, 01 left, 10 right, 11 disabled.
// - analogue mute bit mutes analogue outputs in bit-stream operation.
package dac_volume_pkg;
  localparam int          ADDR_W  = 7;
  localparam int          DATA_W  = 9;
  localparam int          ATTEN_W = 10;
  localparam int          HALF_W  = 5;
  localparam int          MODE_W  = 2;
  localparam int          SAMPLE_W = 24;
  localparam int          ZERO_RUN = 1024;
  // register offsets
  localparam logic [6:0]  OFS_LEFT_LOW   = 7'h00;
  localparam logic [6:0]  OFS_LEFT_HIGH  = 7'h01;
  localparam logic [6:0]  OFS_RIGHT_LOW  = 7'h02;
  localparam logic [6:0]  OFS_RIGHT_HIGH = 7'h03;
  localparam logic [6:0]  OFS_VOLUME     = 7'h04;
  localparam logic [6:0]  OFS_FORMAT     = 7'h05;
  localparam logic [6:0]  OFS_FILTER     = 7'h06;
  localparam logic [6:0]  OFS_MODE_FIRST = 7'h07;
  localparam logic [6:0]  OFS_MODE_SECOND = 7'h08;
  localparam logic [6:0]  OFS_SOFT_RESET = 7'h09;
  localparam logic [6:0]  OFS_ADD_FIRST  = 7'h20;
  // reset values
  localparam logic [8:0]  RST_ATTEN      = 9'h000;
  localparam logic [8:0]  RST_VOLUME     = 9'h000;
  localparam logic [8:0]  RST_FORMAT     = 9'h00A;
  localparam logic [8:0]  RST_FILTER     = 9'h000;
  localparam logic [8:0]  RST_MODE_FIRST = 9'h000;
  localparam logic [8:0]  RST_MODE_SECOND = 9'h002;
  localparam logic [8:0]  RST_ADD_FIRST  = 9'h000;
  // field positions and masks
  localparam int          APPLY_BIT      = 5;
  localparam int          GRADUAL_BIT    = 0;
  localparam int          HEADROOM_BIT   = 1;
  localparam int          LINK_BIT       = 2;
  localparam int          SOFT_MUTE_BIT  = 3;
  localparam int          ZERO_EN_BIT    = 4;
  localparam int          ZSRC_LSB       = 5;
  localparam int          SILENCE_BIT    = 7;
  localparam int          FORCE_HIGH_BIT = 7;
  localparam logic [8:0]  MASK_FORMAT    = 9'h0FF;
  localparam logic [8:0]  MASK_FILTER    = 9'h0FF;
  localparam logic [8:0]  MASK_MODE_FIRST = 9'h0FF;
  localparam logic [8:0]  MASK_MODE_SECOND = 9'h0FF;
  localparam logic [8:0]  MASK_ADD_FIRST = 9'h003;
  // indicator source codes and operating modes
  localparam logic [1:0]  ZSRC_BOTH      = 2'h0;
  localparam logic [1:0]  ZSRC_LEFT      = 2'h1;
  localparam logic [1:0]  ZSRC_RIGHT     = 2'h2;
  localparam logic [1:0]  MODE_PCM       = 2'h0;
endpackage

// ---- atten_ramp.sv ----
`timescale 1ns/100ps
// one channel's attenuation in effect, stepped or ramped toward its target
module atten_ramp #(
  parameter int WIDTH = 10
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // control
  input  wire logic [WIDTH-1:0] i_target,
  input  wire logic             i_gradual,
  input  wire logic             i_step,
  // level in effect
  output logic      [WIDTH-1:0] o_level
);
  // step moves at once; ramp moves one code per sample tick
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= '0;
    end else if (!i_gradual) begin
      o_level <= i_target;
    end else if (i_step && o_level < i_target) begin
      o_level <= o_level + WIDTH'(1);
    end else if (i_step && o_level > i_target) begin
      o_level <= o_level - WIDTH'(1);
    end
  end
endmodule

// ---- zero_run_detect.sv ----
`timescale 1ns/100ps
// flags a channel after a run of zero samples while enabled
module zero_run_detect #(
  parameter int SAMPLE_W = 24,
  parameter int RUN      = 1024
) (
  // clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  // sample stream
  input  wire logic                i_enable,
  input  wire logic                i_valid,
  input  wire logic [SAMPLE_W-1:0] i_sample,
  // status
  output logic                     o_zero
);
  localparam int CNT_W = $clog2(RUN + 1);
  localparam logic [CNT_W-1:0] RUN_LAST = CNT_W'(RUN - 1);
  logic [CNT_W-1:0] count;

  // counts consecutive zero samples, any non-zero sample restarts
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      count  <= '0;
      o_zero <= 1'b0;
    end else if (!i_enable) begin
      count  <= '0;
      o_zero <= 1'b0;
    end else if (i_valid && i_sample != '0) begin
      count  <= '0;
      o_zero <= 1'b0;
    end else if (i_valid && !o_zero) begin
      if (count == RUN_LAST) begin
        o_zero <= 1'b1;
      end
      count <= count + CNT_W'(1);
    end
  end
endmodule

// ---- dac_volume_control_regs.sv ----
`timescale 1ns/100ps
// control register bank: staged attenuation, volume and mute controls
module dac_volume_control_regs #(
  parameter int SAMPLE_W = dac_volume_pkg::SAMPLE_W,
  parameter int ZERO_RUN = dac_volume_pkg::ZERO_RUN
) (
  // clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  // decoded serial control port, write side
  input  wire logic                i_wr_en,
  input  wire logic [6:0]          i_wr_addr,
  input  wire logic [8:0]          i_wr_data,
  // decoded serial control port, read side
  input  wire logic [6:0]          i_rd_addr,
  output logic      [8:0]          o_rd_data,
  // audio sample stream
  input  wire logic                i_sample_valid,
  input  wire logic [SAMPLE_W-1:0] i_left_sample,
  input  wire logic [SAMPLE_W-1:0] i_right_sample,
  // attenuation in effect
  output logic      [9:0]          o_left_attenuation,
  output logic      [9:0]          o_right_attenuation,
  // path controls
  output logic                     o_headroom_cut,
  output logic                     o_soft_mute,
  output logic                     o_analogue_silence_bitstream,
  output logic                     o_zero_indicator_pin,
  // other control registers for the rest of the device
  output logic      [8:0]          o_format_control,
  output logic      [8:0]          o_filter_control,
  output logic      [8:0]          o_mode_control_first,
  output logic      [8:0]          o_mode_control_second,
  output logic      [8:0]          o_additional_control_first
);
  // staged attenuation halves
  logic [4:0] left_low;
  logic [4:0] left_high;
  logic [4:0] right_low;
  logic [4:0] right_high;
  // attenuation words in effect after an apply
  logic [9:0] left_active;
  logic [9:0] right_active;
  // volume register and the pending soft reset
  logic [8:0] volume_and_mute_control;
  logic       soft_reset_req;
  // per-channel zero status
  logic       left_zero;
  logic       right_zero;
  // write decode
  logic       wr_atten;
  logic       wr_apply;
  // derived selects
  logic [9:0] right_target;
  logic [1:0] zsrc;
  logic       next_zero_pin;
  logic       bitstream;

  // true when a write hits the given offset
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    return a == ofs;
  endfunction

  // read-back word of a staged half; apply and reserved bits read zero
  function automatic logic [8:0] half_rd(input logic [4:0] h);
    return {4'h0, h};
  endfunction

  // any of the four attenuation registers
  assign wr_atten = i_wr_en && i_wr_addr <= dac_volume_pkg::OFS_RIGHT_HIGH;
  assign wr_apply = wr_atten && i_wr_data[dac_volume_pkg::APPLY_BIT];

  // staged halves store on every write, apply or not
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      left_low   <= dac_volume_pkg::RST_ATTEN[4:0];
      left_high  <= dac_volume_pkg::RST_ATTEN[4:0];
      right_low  <= dac_volume_pkg::RST_ATTEN[4:0];
      right_high <= dac_volume_pkg::RST_ATTEN[4:0];
    end else if (soft_reset_req) begin
      left_low   <= dac_volume_pkg::RST_ATTEN[4:0];
      left_high  <= dac_volume_pkg::RST_ATTEN[4:0];
      right_low  <= dac_volume_pkg::RST_ATTEN[4:0];
      right_high <= dac_volume_pkg::RST_ATTEN[4:0];
    end else if (i_wr_en) begin
      if (hit(i_wr_addr, dac_volume_pkg::OFS_LEFT_LOW)) begin
        left_low <= i_wr_data[4:0];
      end
      if (hit(i_wr_addr, dac_volume_pkg::OFS_LEFT_HIGH)) begin
        left_high <= i_wr_data[4:0];
      end
      if (hit(i_wr_addr, dac_volume_pkg::OFS_RIGHT_LOW)) begin
        right_low <= i_wr_data[4:0];
      end
      if (hit(i_wr_addr, dac_volume_pkg::OFS_RIGHT_HIGH)) begin
        right_high <= i_wr_data[4:0];
      end
    end
  end

  // apply: all four stored halves, including the one just written, take
  // effect together; the written value bypasses the staging register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      left_active  <= {dac_volume_pkg::RST_ATTEN[4:0],
                       dac_volume_pkg::RST_ATTEN[4:0]};
      right_active <= {dac_volume_pkg::RST_ATTEN[4:0],
                       dac_volume_pkg::RST_ATTEN[4:0]};
    end else if (soft_reset_req) begin
      left_active  <= {dac_volume_pkg::RST_ATTEN[4:0],
                       dac_volume_pkg::RST_ATTEN[4:0]};
      right_active <= {dac_volume_pkg::RST_ATTEN[4:0],
                       dac_volume_pkg::RST_ATTEN[4:0]};
    end else if (wr_apply) begin
      left_active <= {
        hit(i_wr_addr, dac_volume_pkg::OFS_LEFT_HIGH) ?
          i_wr_data[4:0] : left_high,
        hit(i_wr_addr, dac_volume_pkg::OFS_LEFT_LOW) ?
          i_wr_data[4:0] : left_low};
      right_active <= {
        hit(i_wr_addr, dac_volume_pkg::OFS_RIGHT_HIGH) ?
          i_wr_data[4:0] : right_high,
        hit(i_wr_addr, dac_volume_pkg::OFS_RIGHT_LOW) ?
          i_wr_data[4:0] : right_low};
    end
  end

  // volume and mute control register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      volume_and_mute_control <= dac_volume_pkg::RST_VOLUME;
    end else if (soft_reset_req) begin
      volume_and_mute_control <= dac_volume_pkg::RST_VOLUME;
    end else if (i_wr_en && hit(i_wr_addr, dac_volume_pkg::OFS_VOLUME)) begin
      volume_and_mute_control <= {1'b0, i_wr_data[7:0]};
    end
  end

  // remaining control registers, held for the rest of the device
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_format_control           <= dac_volume_pkg::RST_FORMAT;
      o_filter_control           <= dac_volume_pkg::RST_FILTER;
      o_mode_control_first       <= dac_volume_pkg::RST_MODE_FIRST;
      o_mode_control_second      <= dac_volume_pkg::RST_MODE_SECOND;
      o_additional_control_first <= dac_volume_pkg::RST_ADD_FIRST;
    end else if (soft_reset_req) begin
      o_format_control           <= dac_volume_pkg::RST_FORMAT;
      o_filter_control           <= dac_volume_pkg::RST_FILTER;
      o_mode_control_first       <= dac_volume_pkg::RST_MODE_FIRST;
      o_mode_control_second      <= dac_volume_pkg::RST_MODE_SECOND;
      o_additional_control_first <= dac_volume_pkg::RST_ADD_FIRST;
    end else if (i_wr_en) begin
      if (hit(i_wr_addr, dac_volume_pkg::OFS_FORMAT)) begin
        o_format_control <= i_wr_data & dac_volume_pkg::MASK_FORMAT;
      end
      if (hit(i_wr_addr, dac_volume_pkg::OFS_FILTER)) begin
        o_filter_control <= i_wr_data & dac_volume_pkg::MASK_FILTER;
      end
      if (hit(i_wr_addr, dac_volume_pkg::OFS_MODE_FIRST)) begin
        o_mode_control_first <= i_wr_data & dac_volume_pkg::MASK_MODE_FIRST;
      end
      if (hit(i_wr_addr, dac_volume_pkg::OFS_MODE_SECOND)) begin
        o_mode_control_second <=
          i_wr_data & dac_volume_pkg::MASK_MODE_SECOND;
      end
      if (hit(i_wr_addr, dac_volume_pkg::OFS_ADD_FIRST)) begin
        o_additional_control_first <=
          i_wr_data & dac_volume_pkg::MASK_ADD_FIRST;
      end
    end
  end

  // any write to the soft reset register restores defaults next cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      soft_reset_req <= 1'b0;
    end else begin
      soft_reset_req <= i_wr_en &&
                        hit(i_wr_addr, dac_volume_pkg::OFS_SOFT_RESET);
    end
  end

  // right channel can follow the left attenuation
  assign right_target = volume_and_mute_control[dac_volume_pkg::LINK_BIT] ?
                        left_active : right_active;

  // per-channel step or ramp toward the attenuation in effect
  atten_ramp #(
    .WIDTH     (dac_volume_pkg::ATTEN_W)
  ) u_left_ramp (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_target  (left_active),
    .i_gradual (volume_and_mute_control[dac_volume_pkg::GRADUAL_BIT]),
    .i_step    (i_sample_valid),
    .o_level   (o_left_attenuation)
  );

  atten_ramp #(
    .WIDTH     (dac_volume_pkg::ATTEN_W)
  ) u_right_ramp (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_target  (right_target),
    .i_gradual (volume_and_mute_control[dac_volume_pkg::GRADUAL_BIT]),
    .i_step    (i_sample_valid),
    .o_level   (o_right_attenuation)
  );

  // zero run detection per channel
  zero_run_detect #(
    .SAMPLE_W (SAMPLE_W),
    .RUN      (ZERO_RUN)
  ) u_left_zero (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_enable (volume_and_mute_control[dac_volume_pkg::ZERO_EN_BIT]),
    .i_valid  (i_sample_valid),
    .i_sample (i_left_sample),
    .o_zero   (left_zero)
  );

  zero_run_detect #(
    .SAMPLE_W (SAMPLE_W),
    .RUN      (ZERO_RUN)
  ) u_right_zero (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_enable (volume_and_mute_control[dac_volume_pkg::ZERO_EN_BIT]),
    .i_valid  (i_sample_valid),
    .i_sample (i_right_sample),
    .o_zero   (right_zero)
  );

  // indicator source field
  assign zsrc = volume_and_mute_control[dac_volume_pkg::ZSRC_LSB +: 2];

  // source select; the filter register's force-high bit overrides
  always_comb begin
    case (zsrc)
      dac_volume_pkg::ZSRC_BOTH:  next_zero_pin = left_zero & right_zero;
      dac_volume_pkg::ZSRC_LEFT:  next_zero_pin = left_zero;
      dac_volume_pkg::ZSRC_RIGHT: next_zero_pin = right_zero;
      default:                    next_zero_pin = 1'b0;
    endcase
    if (o_filter_control[dac_volume_pkg::FORCE_HIGH_BIT]) begin
      next_zero_pin = 1'b1;
    end
  end

  // bit-stream operation is any mode other than sample input
  assign bitstream = o_mode_control_first[dac_volume_pkg::MODE_W-1:0] !=
                     dac_volume_pkg::MODE_PCM;

  // registered path controls
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_headroom_cut               <= 1'b0;
      o_soft_mute                  <= 1'b0;
      o_analogue_silence_bitstream <= 1'b0;
    end else begin
      o_headroom_cut <=
        volume_and_mute_control[dac_volume_pkg::HEADROOM_BIT];
      o_soft_mute <=
        volume_and_mute_control[dac_volume_pkg::SOFT_MUTE_BIT];
      o_analogue_silence_bitstream <= bitstream &&
        volume_and_mute_control[dac_volume_pkg::SILENCE_BIT];
    end
  end

  // registered zero indicator
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_zero_indicator_pin <= 1'b0;
    end else begin
      o_zero_indicator_pin <= next_zero_pin;
    end
  end

  // read back: stored values, apply bits and reserved bits read zero
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= 9'h000;
    end else begin
      case (i_rd_addr)
        dac_volume_pkg::OFS_LEFT_LOW:    o_rd_data <= half_rd(left_low);
        dac_volume_pkg::OFS_LEFT_HIGH:   o_rd_data <= half_rd(left_high);
        dac_volume_pkg::OFS_RIGHT_LOW:   o_rd_data <= half_rd(right_low);
        dac_volume_pkg::OFS_RIGHT_HIGH:  o_rd_data <= half_rd(right_high);
        dac_volume_pkg::OFS_VOLUME:      o_rd_data <= volume_and_mute_control;
        dac_volume_pkg::OFS_FORMAT:      o_rd_data <= o_format_control;
        dac_volume_pkg::OFS_FILTER:      o_rd_data <= o_filter_control;
        dac_volume_pkg::OFS_MODE_FIRST:  o_rd_data <= o_mode_control_first;
        dac_volume_pkg::OFS_MODE_SECOND: o_rd_data <= o_mode_control_second;
        dac_volume_pkg::OFS_ADD_FIRST:
          o_rd_data <= o_additional_control_first;
        default:                         o_rd_data <= 9'h000;
      endcase
    end
  end
endmodule

// ---- dac_volume_control_regs_chk.sv ----
`timescale 1ns/100ps
// port checker for the control register bank
module dac_volume_control_regs_chk #(
  parameter int SAMPLE_W = 24,
  parameter int ZERO_RUN = 1024
) (
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_rst,
  // control port
  input wire logic       i_wr_en,
  input wire logic [6:0] i_wr_addr,
  input wire logic [8:0] i_wr_data,
  input wire logic [6:0] i_rd_addr,
  input wire logic [8:0] o_rd_data,
  // controls in effect
  input wire logic [9:0] o_left_attenuation,
  input wire logic [9:0] o_right_attenuation,
  input wire logic       o_headroom_cut,
  input wire logic       o_soft_mute,
  input wire logic       o_analogue_silence_bitstream,
  input wire logic       o_zero_indicator_pin
);
  logic [7:0] vol_q;
  logic [1:0] mode_q;
  logic       force_q;
  logic [2:0] sr_hold;
  // mirror of written controls; soft reset clears it and mutes checks
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      vol_q   <= 8'h00;
      mode_q  <= 2'h0;
      force_q <= 1'b0;
      sr_hold <= 3'h0;
    end else if (i_wr_en && i_wr_addr == 7'h09) begin
      vol_q   <= 8'h00;
      mode_q  <= 2'h0;
      force_q <= 1'b0;
      sr_hold <= 3'h5;
    end else begin
      if (sr_hold != 3'h0) sr_hold <= sr_hold - 3'h1;
      if (i_wr_en && i_wr_addr == 7'h04) vol_q <= i_wr_data[7:0];
      if (i_wr_en && i_wr_addr == 7'h07) mode_q <= i_wr_data[1:0];
      if (i_wr_en && i_wr_addr == 7'h06) force_q <= i_wr_data[7];
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst || sr_hold != 3'h0);
  // a write to the volume register
  sequence vol_wr_s;
    i_wr_en && i_wr_addr == 7'h04;
  endsequence
  // a write to an attenuation register with the given apply bit
  sequence att_wr_s(logic ap);
    i_wr_en && i_wr_addr <= 7'h03 && i_wr_data[5] == ap;
  endsequence
  read_vol_a: assert property (
    vol_wr_s ##1 i_rd_addr == 7'h04
    |=> o_rd_data == {1'b0, $past(i_wr_data[7:0], 2)})
    else $error("volume readback wrong");
  hold_staged_a: assert property (
    att_wr_s(1'b0) ##0 (!vol_q[0] && !$past(i_wr_en))
    |=> $stable(o_left_attenuation) [*2])
    else $error("staged write changed attenuation");
  apply_step_a: assert property (
    att_wr_s(1'b1) ##0 (i_wr_addr == 7'h00 && !vol_q[0])
    |=> ##1 o_left_attenuation[4:0] == $past(i_wr_data[4:0], 2))
    else $error("apply did not step attenuation");
  ramp_step_a: assert property (
    vol_q[0] && $past(vol_q[0]) |-> (o_left_attenuation
    - $past(o_left_attenuation)) inside {10'h000, 10'h001, 10'h3FF})
    else $error("ramp moved more than one code");
  headroom_a: assert property (
    vol_wr_s |=> ##1 o_headroom_cut == $past(i_wr_data[1], 2))
    else $error("headroom cut wrong");
  link_a: assert property (
    vol_q[2] && $past(vol_q[2], 2) && !vol_q[0]
    && $stable(o_left_attenuation)
    |-> o_right_attenuation == o_left_attenuation)
    else $error("right does not follow left");
  soft_mute_a: assert property (
    vol_wr_s ##2 1'b1 |-> o_soft_mute == $past(i_wr_data[3], 2))
    else $error("soft mute wrong");
  zero_dis_a: assert property (
    !$past(vol_q[4], 2) && !$past(vol_q[4]) && !$past(force_q)
    |-> !o_zero_indicator_pin)
    else $error("zero pin high while detect off");
  zero_off_a: assert property (
    $past(vol_q[6:5]) == 2'h3 && !$past(force_q)
    |-> !o_zero_indicator_pin)
    else $error("zero pin high while disabled");
  analogue_mute_a: assert property (
    vol_wr_s |=> ##1 o_analogue_silence_bitstream
    == ($past(i_wr_data[7], 2) && $past(mode_q) != 2'h0))
    else $error("analogue mute wrong");
endmodule
bind dac_volume_control_regs dac_volume_control_regs_chk #(
  .SAMPLE_W(SAMPLE_W),
  .ZERO_RUN(ZERO_RUN)
) chk (.i_mclk, .i_rst, .i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_addr,
  .o_rd_data, .o_left_attenuation, .o_right_attenuation, .o_headroom_cut,
  .o_soft_mute, .o_analogue_silence_bitstream, .o_zero_indicator_pin);

// ---- host_model.sv ----
`timescale 1ns/100ps
// host side of the decoded control port, drives at falling edges
module host_model (
  // clock
  input  wire logic       i_mclk,
  // control port
  input  wire logic [8:0] i_rd_data,
  output logic            o_wr_en,
  output logic      [6:0] o_wr_addr,
  output logic      [8:0] o_wr_data,
  output logic      [6:0] o_rd_addr
);
  // idle port; read address parks on the volume register
  initial begin
    o_wr_en   = 1'b0;
    o_wr_addr = 7'h7F;
    o_wr_data = 9'h1AA;
    o_rd_addr = 7'h04;
  end
  // one write; released lines show the inverse, not the last value
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge i_mclk);
    o_wr_en   = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_mclk);
    o_wr_en   = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
  endtask
  // read: data one edge after the address
  task automatic rd(input logic [6:0] a, output logic [8:0] d);
    @(negedge i_mclk);
    o_rd_addr = a;
    @(negedge i_mclk);
    d = i_rd_data;
    o_rd_addr = 7'h04;
  endtask
  // staged change: apply only on the last write
  task automatic stage(input logic [4:0] ll, lh, rl, rh);
    wr(7'h00, {4'h0, ll});
    wr(7'h01, {4'h0, lh});
    wr(7'h02, {4'h0, rl});
    wr(7'h03, {4'h1, rh});
  endtask
endmodule

// ---- dac_volume_control_regs_tb.sv ----
`timescale 1ns/100ps
// self-checking bench for the control register bank
module dac_volume_control_regs_tb;
  localparam int         RUN = 8;
  localparam logic [6:0] ADR [12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
    7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h20, 7'h0A};
  localparam logic [8:0] RST [12] = '{9'h000, 9'h000, 9'h000, 9'h000,
    9'h000, 9'h00A, 9'h000, 9'h000, 9'h002, 9'h000, 9'h000, 9'h000};
  localparam logic [8:0] MSK [12] = '{9'h01F, 9'h01F, 9'h01F, 9'h01F,
    9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF, 9'h0FF, 9'h000, 9'h003, 9'h000};
  logic        i_mclk;
  logic        i_rst;
  logic        i_wr_en;
  logic [6:0]  i_wr_addr;
  logic [8:0]  i_wr_data;
  logic [6:0]  i_rd_addr;
  logic [8:0]  o_rd_data;
  logic        i_sample_valid;
  logic [23:0] i_left_sample;
  logic [23:0] i_right_sample;
  logic [9:0]  o_left_attenuation;
  logic [9:0]  o_right_attenuation;
  logic        o_headroom_cut;
  logic        o_soft_mute;
  logic        o_analogue_silence_bitstream;
  logic        o_zero_indicator_pin;
  logic [8:0]  rd_v;
  logic [8:0]  ctl [5];
  int          errors;
  int          comparisons;
  dac_volume_control_regs #(.SAMPLE_W(24), .ZERO_RUN(RUN)) dut (
    .i_mclk, .i_rst, .i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_addr,
    .o_rd_data, .i_sample_valid, .i_left_sample, .i_right_sample,
    .o_left_attenuation, .o_right_attenuation, .o_headroom_cut,
    .o_soft_mute, .o_analogue_silence_bitstream, .o_zero_indicator_pin,
    .o_format_control(ctl[0]), .o_filter_control(ctl[1]),
    .o_mode_control_first(ctl[2]), .o_mode_control_second(ctl[3]),
    .o_additional_control_first(ctl[4]));
  host_model host (.i_mclk, .i_rd_data(o_rd_data), .o_wr_en(i_wr_en),
    .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data), .o_rd_addr(i_rd_addr));
  // 100 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // compare and count
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [8:0] exp);
    host.rd(a, rd_v);
    chk({1'b0, rd_v}, {1'b0, exp});
  endtask
  // one stereo sample pulse
  task automatic smp(input logic [23:0] l, input logic [23:0] r);
    @(negedge i_mclk);
    i_sample_valid = 1'b1;
    i_left_sample  = l;
    i_right_sample = r;
    @(negedge i_mclk);
    i_sample_valid = 1'b0;
    i_left_sample  = ~l;
    i_right_sample = ~r;
  endtask
  task automatic settle;
    repeat (3) @(negedge i_mclk);
  endtask
  task automatic end_sim;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    errors++;
    end_sim();
  end
  // test sequence
  initial begin
    errors = 0;
    comparisons = 0;
    i_rst = 1'b1;
    i_sample_valid = 1'b0;
    i_left_sample = 24'h5A5A5A;
    i_right_sample = 24'hA5A5A5;
    repeat (20) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    for (int k = 0; k < 12; k++) rdchk(ADR[k], RST[k]);
    host.stage(5'h05, 5'h03, 5'h07, 5'h01);
    settle();
    chk(o_left_attenuation, 10'h065);
    chk(o_right_attenuation, 10'h027);
    host.wr(7'h00, 9'h008);
    settle();
    chk(o_left_attenuation, 10'h065);
    rdchk(7'h00, 9'h008);
    host.wr(7'h04, 9'h004);
    settle();
    chk(o_right_attenuation, 10'h065);
    host.wr(7'h04, 9'h000);
    settle();
    chk(o_right_attenuation, 10'h027);
    // ramp: one code per sample pulse toward 0x06A
    host.wr(7'h04, 9'h001);
    host.wr(7'h00, 9'h02A);
    settle();
    chk(o_left_attenuation, 10'h065);
    for (int k = 1; k < 7; k++) begin
      smp(24'h000001, 24'h000001);
      chk(o_left_attenuation, (k < 5) ? 10'h065 + 10'(k) : 10'h06A);
    end
    // ramp down one code toward 0x068
    host.wr(7'h00, 9'h028);
    smp(24'h000001, 24'h000001);
    chk(o_left_attenuation, 10'h069);
    // headroom, soft mute, analogue mute in and out of bit-stream mode
    for (int k = 0; k < 4; k++) begin
      if (k == 3) host.wr(7'h07, 9'h001);
      host.wr(7'h04, (k == 0) ? 9'h002 : (k == 1) ? 9'h008 : 9'h080);
      settle();
      chk({7'h00, o_headroom_cut, o_soft_mute, o_analogue_silence_bitstream},
        (k == 0) ? 10'h004 : (k == 1) ? 10'h002 : 10'(k == 3));
    end
    host.wr(7'h07, 9'h000);
    // zero runs: both channels, then left only, over every source
    host.wr(7'h04, 9'h010);
    repeat (RUN - 1) smp(24'h000000, 24'h000000);
    settle();
    chk({9'h000, o_zero_indicator_pin}, 10'h000);
    smp(24'h000000, 24'h000000);
    settle();
    chk({9'h000, o_zero_indicator_pin}, 10'h001);
    smp(24'h000000, 24'h000100);
    for (int k = 0; k < 4; k++) begin
      host.wr(7'h04, 9'h010 | 9'(k << 5));
      settle();
      chk({9'h000, o_zero_indicator_pin}, 10'(k == 1));
    end
    host.wr(7'h04, 9'h020);
    settle();
    chk({9'h000, o_zero_indicator_pin}, 10'h000);
    // masks, unmapped write, then soft reset restores defaults
    for (int k = 0; k < 12; k++) if (k != 9) host.wr(ADR[k], 9'h1FF);
    chk(o_left_attenuation, 10'h3FF);
    chk({9'h000, o_zero_indicator_pin}, 10'h001);
    for (int k = 0; k < 12; k++) rdchk(ADR[k], MSK[k]);
    for (int k = 0; k < 5; k++) chk({1'b0, ctl[k]},
      {1'b0, MSK[k + 5 + int'(k == 4)]});
    host.wr(7'h09, 9'h100);
    settle();
    for (int k = 0; k < 12; k++) rdchk(ADR[k], RST[k]);
    for (int k = 0; k < 5; k++) chk({1'b0, ctl[k]},
      {1'b0, RST[k + 5 + int'(k == 4)]});
    end_sim();
  end
endmodule
